// ==== hsq_pkg.sv ====
`default_nettype none
package hsq_pkg;
    // ==========================================================
    // Register offsets (byte addresses, one word each).
    localparam logic [7:0] HSQ_CTRL_OFS   = 8'h00;
    localparam logic [7:0] HSQ_FAST_OFS   = 8'h04;
    localparam logic [7:0] HSQ_SLOW_OFS   = 8'h08;
    localparam logic [7:0] HSQ_TURNS_OFS  = 8'h0c;
    localparam logic [7:0] HSQ_PULSES_OFS = 8'h10;
    localparam logic [7:0] HSQ_STATUS_OFS = 8'h14;
    // ==========================================================
    // Control field positions.
    localparam int HSQ_REF_LSB   = 0;
    localparam int HSQ_FINE_LSB  = 4;
    localparam int HSQ_MODE_LSB  = 8;
    localparam int HSQ_STOP_BIT  = 12;
    // ==========================================================
    // Reset values and the limits that writes are clamped to.
    localparam logic [2:0]  HSQ_REF_RST   = 3'h0;
    localparam logic [1:0]  HSQ_FINE_RST  = 2'h0;
    localparam logic [1:0]  HSQ_MODE_RST  = 2'h0;
    localparam logic [10:0] HSQ_FAST_RST  = 11'h3e8;
    localparam logic [10:0] HSQ_FAST_MAX  = 11'h7d0;
    localparam logic [8:0]  HSQ_SLOW_RST  = 9'h032;
    localparam logic [8:0]  HSQ_SLOW_MAX  = 9'h1f4;
    localparam logic [15:0] HSQ_TURNS_MAX = 16'h7530;
    // ==========================================================
    // Start modes, reference sources and fine-search choices.
    localparam logic [1:0] HSQ_MODE_OFF   = 2'h0;
    localparam logic [1:0] HSQ_MODE_POWER = 2'h1;
    localparam logic [1:0] HSQ_MODE_INPUT = 2'h2;
    localparam logic [2:0] HSQ_REF_FWDLIM = 3'h0;
    localparam logic [2:0] HSQ_REF_REVLIM = 3'h1;
    localparam logic [2:0] HSQ_REF_ABSFWD = 3'h4;
    localparam logic [2:0] HSQ_REF_ABSREV = 3'h5;
    localparam logic [1:0] HSQ_FINE_REVZ  = 2'h0;
    localparam logic [1:0] HSQ_FINE_EDGE  = 2'h2;
    typedef enum logic [1:0] {
        HSQ_IDLE, HSQ_COARSE, HSQ_FINE, HSQ_OFFSET
    } hsq_state_t;
endpackage : hsq_pkg
`default_nettype wire

// ==== hsq_edge.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==============================================================
// Rising edge finder for a group of synchronous inputs.
module hsq_edge #(
    parameter int WIDTH = 7
) (
    // Clock and reset.
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Levels in, registered one-cycle edge pulses out.
    input  wire logic [WIDTH-1:0] level,
    output var  logic [WIDTH-1:0] rise_q
);
    logic [WIDTH-1:0] prev_q;

    // The previous level and its rising edges are both registered.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= '0;
            rise_q <= '0;
        end else begin
            prev_q <= level;
            rise_q <= level & ~prev_q;
        end
    end
endmodule : hsq_edge
`default_nettype wire

// ==== hsq_homing.sv ====
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hsq_homing
    import hsq_pkg::*;
#(
    parameter int PULSES_PER_REV = 10000
) (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Drive status and field inputs.
    input  wire logic        servoEnable,
    input  wire logic        homeStartInput,
    input  wire logic        forwardLimitInput,
    input  wire logic        reverseLimitInput,
    input  wire logic        originSensorInput,
    input  wire logic        indexPulse,
    input  wire logic        singleTurnZero,
    // Motion profile interface.
    input  wire logic        offsetAck,
    output var  logic        moveEnable,
    output var  logic        moveReverse,
    output var  logic [10:0] speedCmd,
    output var  logic        offsetReq,
    output var  logic [15:0] offsetTurns,
    output var  logic [31:0] offsetPulses,
    // Status.
    output var  logic        homeBusy,
    output var  logic        homeDone,
    output var  logic        forwardLimitWarn,
    output var  logic        reverseLimitWarn
);
    // ==========================================================
    // Parameter check.
    if (PULSES_PER_REV < 2 || PULSES_PER_REV > 32'h3fffffff) begin : g_chk
        $error("PULSES_PER_REV out of range");
    end
    localparam logic [31:0] PPR = 32'(PULSES_PER_REV);

    // Clamp a signed word to plus or minus a bound.
    function automatic logic [31:0] clampS(input logic [31:0] v,
                                           input logic [31:0] lim);
        if ($signed(v) > $signed(lim)) return lim;
        if ($signed(v) < -$signed(lim)) return -lim;
        return v;
    endfunction : clampS

    // Clamp an unsigned speed into one to a maximum.
    function automatic logic [31:0] clampU(input logic [31:0] v,
                                           input logic [31:0] lim);
        if (v == 32'h0) return 32'h1;
        if (v > lim) return lim;
        return v;
    endfunction : clampU

    // ==========================================================
    // Register file.
    logic [2:0]  refSel_q;
    logic [1:0]  fineSel_q;
    logic [1:0]  startMode_q;
    logic        stopSel_q;
    logic [10:0] fastSpd_q;
    logic [8:0]  slowSpd_q;
    logic [15:0] turns_q;
    logic [31:0] pulses_q;
    hsq_state_t  state_q;
    logic        ranOnce_q;
    logic [2:0]  runRef_q;
    logic [1:0]  runFine_q;
    logic        wrEn;
    logic        acc;
    logic [6:0]  rise;
    logic        startReq;
    logic        coarseHit;
    logic        fineHit;
    logic        limitRef;

    assign acc  = psel & penable & ~pready;
    assign wrEn = psel & penable & pready & pwrite;

    // Writes land at the ready edge, clamped into the legal ranges.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            refSel_q    <= HSQ_REF_RST;
            fineSel_q   <= HSQ_FINE_RST;
            startMode_q <= HSQ_MODE_RST;
            stopSel_q   <= 1'b0;
            fastSpd_q   <= HSQ_FAST_RST;
            slowSpd_q   <= HSQ_SLOW_RST;
            turns_q     <= '0;
            pulses_q    <= '0;
        end else if (wrEn) begin
            case (paddr)
                HSQ_CTRL_OFS: begin
                    refSel_q    <= pwdata[HSQ_REF_LSB +: 3];
                    fineSel_q   <= pwdata[HSQ_FINE_LSB +: 2];
                    startMode_q <= pwdata[HSQ_MODE_LSB +: 2];
                    stopSel_q   <= pwdata[HSQ_STOP_BIT];
                end
                HSQ_FAST_OFS: fastSpd_q <= 11'(clampU(pwdata,
                                   32'(HSQ_FAST_MAX)));
                HSQ_SLOW_OFS: slowSpd_q <= 9'(clampU(pwdata,
                                   32'(HSQ_SLOW_MAX)));
                HSQ_TURNS_OFS: turns_q <= 16'(clampS(pwdata,
                                   32'(HSQ_TURNS_MAX)));
                HSQ_PULSES_OFS: pulses_q <= clampS(pwdata, PPR);
                default: ;
            endcase
        end
    end

    // ==========================================================
    // APB answer: one wait cycle, then ready with data or error.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (acc) begin
                case (paddr)
                    HSQ_CTRL_OFS: prdata <= {19'h0, stopSel_q, 2'h0,
                        startMode_q, 2'h0, fineSel_q, 1'b0, refSel_q};
                    HSQ_FAST_OFS:   prdata <= {21'h0, fastSpd_q};
                    HSQ_SLOW_OFS:   prdata <= {23'h0, slowSpd_q};
                    HSQ_TURNS_OFS:  prdata <= {{16{turns_q[15]}}, turns_q};
                    HSQ_PULSES_OFS: prdata <= pulses_q;
                    HSQ_STATUS_OFS: prdata <= {24'h0, ranOnce_q,
                        reverseLimitWarn, forwardLimitWarn, 1'b0,
                        state_q, homeDone, homeBusy};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ==========================================================
    // Edge pulses: start, enable, limits, sensor, index, zero.
    hsq_edge #(.WIDTH(7)) u_edge (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .level   ({singleTurnZero, indexPulse, originSensorInput,
                   reverseLimitInput, forwardLimitInput, servoEnable,
                   homeStartInput}),
        .rise_q  (rise)
    );

    // Start decode; only looked at while idle, so busy ignores it.
    always_comb begin
        startReq = 1'b0;
        case (startMode_q)
            HSQ_MODE_OFF:   startReq = 1'b0;
            HSQ_MODE_POWER: startReq = rise[1] & ~ranOnce_q;
            HSQ_MODE_INPUT: startReq = rise[0] & servoEnable;
            default:        startReq = 1'b0;
        endcase
    end

    // Coarse and fine reference events for the latched selection.
    always_comb begin
        case (runRef_q)
            HSQ_REF_FWDLIM: coarseHit = rise[2];
            HSQ_REF_REVLIM: coarseHit = rise[3];
            default:        coarseHit = rise[4];
        endcase
        fineHit  = (runRef_q >= HSQ_REF_ABSFWD) ? rise[6] : rise[5];
        limitRef = (runRef_q <= HSQ_REF_REVLIM);
    end

    // ==========================================================
    // The first servo enable edge is remembered until the next reset, in every start mode.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ranOnce_q <= 1'b0;
        end else if (rise[1]) begin
            ranOnce_q <= 1'b1;
        end
    end

    // ==========================================================
    // Sequencer. Dropping servo enable abandons a run without done.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q      <= HSQ_IDLE;
            runRef_q     <= HSQ_REF_RST;
            runFine_q    <= HSQ_FINE_RST;
            moveEnable   <= 1'b0;
            moveReverse  <= 1'b0;
            speedCmd     <= '0;
            offsetReq    <= 1'b0;
            offsetTurns  <= '0;
            offsetPulses <= '0;
            homeBusy     <= 1'b0;
            homeDone     <= 1'b0;
        end else begin
            offsetReq <= 1'b0;
            if (!servoEnable && state_q != HSQ_IDLE) begin
                state_q    <= HSQ_IDLE;
                moveEnable <= 1'b0;
                homeBusy   <= 1'b0;
            end else begin
                case (state_q)
                    HSQ_IDLE: begin
                        if (startReq) begin
                            runRef_q   <= refSel_q;
                            runFine_q  <= fineSel_q;
                            homeBusy   <= 1'b1;
                            homeDone   <= 1'b0;
                            moveEnable <= 1'b1;
                            moveReverse <= refSel_q[0];
                            if (refSel_q >= HSQ_REF_ABSFWD) begin
                                state_q  <= HSQ_FINE;
                                speedCmd <= {2'h0, slowSpd_q};
                            end else begin
                                state_q  <= HSQ_COARSE;
                                speedCmd <= fastSpd_q;
                            end
                        end
                    end
                    HSQ_COARSE: begin
                        if (coarseHit) begin
                            if (runFine_q == HSQ_FINE_EDGE) begin
                                state_q    <= HSQ_OFFSET;
                                moveEnable <= 1'b0;
                                offsetReq  <= 1'b1;
                            end else begin
                                state_q  <= HSQ_FINE;
                                speedCmd <= {2'h0, slowSpd_q};
                                if (runFine_q == HSQ_FINE_REVZ) begin
                                    moveReverse <= ~moveReverse;
                                end
                            end
                        end
                    end
                    HSQ_FINE: begin
                        if (fineHit) begin
                            state_q    <= HSQ_OFFSET;
                            moveEnable <= 1'b0;
                            offsetReq  <= 1'b1;
                        end
                    end
                    HSQ_OFFSET: begin
                        if (offsetAck && !offsetReq) begin
                            state_q  <= HSQ_IDLE;
                            homeBusy <= 1'b0;
                            homeDone <= 1'b1;
                        end
                    end
                    default: state_q <= HSQ_IDLE;
                endcase
            end
            // Offsets are frozen at request time for the mover.
            if (state_q != HSQ_OFFSET) begin
                offsetTurns  <= turns_q;
                offsetPulses <= pulses_q;
            end
        end
    end

    // ==========================================================
    // Limit warnings. A limit used as the coarse reference is muted
    // only while its run is busy; afterwards it is a limit again.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            forwardLimitWarn <= 1'b0;
            reverseLimitWarn <= 1'b0;
        end else begin
            forwardLimitWarn <= servoEnable & forwardLimitInput &
                ~(homeBusy & limitRef & ~runRef_q[0]);
            reverseLimitWarn <= servoEnable & reverseLimitInput &
                ~(homeBusy & limitRef & runRef_q[0]);
        end
    end

    // ==========================================================
    // Checks.
    sequence s_fineDone;
        state_q == HSQ_FINE && fineHit && servoEnable;
    endsequence
    sequence s_offPulse;
        offsetReq ##1 !offsetReq;
    endsequence

    property p_modeOff;
        @(posedge ref_clk) disable iff (!rst_n)
        (startMode_q == HSQ_MODE_OFF && !homeBusy) |=> !homeBusy;
    endproperty
    a_modeOff: assert property (p_modeOff)
        else $error("homing started in mode off");

    property p_once;
        @(posedge ref_clk) disable iff (!rst_n)
        ($rose(homeBusy) && $past(startMode_q) == HSQ_MODE_POWER)
            |-> !$past(ranOnce_q);
    endproperty
    a_once: assert property (p_once)
        else $error("power-up homing ran twice");

    property p_inputStart;
        @(posedge ref_clk) disable iff (!rst_n)
        (startMode_q == HSQ_MODE_INPUT && rise[0] && servoEnable &&
         state_q == HSQ_IDLE) |=> homeBusy && moveEnable;
    endproperty
    a_inputStart: assert property (p_inputStart)
        else $error("input start ignored");

    property p_coarseDir;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == HSQ_COARSE) |-> moveReverse == runRef_q[0];
    endproperty
    a_coarseDir: assert property (p_coarseDir)
        else $error("coarse direction wrong");

    property p_fastSpeed;
        @(posedge ref_clk) disable iff (!rst_n)
        ($past(state_q) == HSQ_IDLE && state_q == HSQ_COARSE)
            |-> speedCmd == $past(fastSpd_q);
    endproperty
    a_fastSpeed: assert property (p_fastSpeed)
        else $error("first stage speed wrong");

    property p_absSlow;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == HSQ_FINE && runRef_q >= HSQ_REF_ABSFWD)
            |-> moveReverse == (runRef_q == HSQ_REF_ABSREV) &&
                speedCmd <= {2'h0, HSQ_SLOW_MAX};
    endproperty
    a_absSlow: assert property (p_absSlow)
        else $error("single-turn zero search wrong");

    property p_offset;
        @(posedge ref_clk) disable iff (!rst_n)
        s_fineDone |=> s_offPulse;
    endproperty
    a_offset: assert property (p_offset)
        else $error("offset not requested after fine search");

    property p_done;
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == HSQ_OFFSET && offsetAck && !offsetReq && servoEnable)
            |=> homeDone && !homeBusy ##1 homeDone;
    endproperty
    a_done: assert property (p_done)
        else $error("done not flagged");

    property p_limitBack;
        @(posedge ref_clk) disable iff (!rst_n)
        (!homeBusy && servoEnable && forwardLimitInput) |=>
            forwardLimitWarn;
    endproperty
    a_limitBack: assert property (p_limitBack)
        else $error("limit warning missing after homing");

    property p_ranges;
        @(posedge ref_clk) disable iff (!rst_n)
        $signed(turns_q) <= $signed(HSQ_TURNS_MAX) &&
        $signed(pulses_q) <= $signed(PPR) && fastSpd_q != 11'h0;
    endproperty
    a_ranges: assert property (p_ranges)
        else $error("setting outside its range");
endmodule : hsq_homing
`default_nettype wire

// ==== hsq_axis_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Axis model: switches, encoder marks and the offset mover.
module hsq_axis_model (
    // Clock and reset.
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Pace of travel and of the mover's answer.
    input  wire logic [2:0] stepDiv,
    input  wire logic [3:0] ackDelay,
    // Motion commands.
    input  wire logic       moveEnable,
    input  wire logic       moveReverse,
    input  wire logic       offsetReq,
    // Field levels and the mover's answer back to the sequencer.
    output logic            fwdLimit,
    output logic            revLimit,
    output logic            origin,
    output logic            zMark,
    output logic            absZero,
    output var logic        offsetAck
);
    int pos;
    int tick;
    int ackCnt;
    // One count every stepDiv+1 cycles, so slow axes stretch each stage.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pos  <= 0;
            tick <= 0;
        end else if (moveEnable && tick >= int'(stepDiv)) begin
            pos  <= moveReverse ? pos - 1 : pos + 1;
            tick <= 0;
        end else begin
            tick <= tick + 1;
        end
    end
    // Levels follow position; the sensor sits at twelve and beyond each way.
    assign fwdLimit = (pos >= 20);
    assign revLimit = (pos <= -20);
    assign origin   = (pos >= 12) || (pos <= -12);
    assign zMark    = (pos[2:0] == 3'h0);
    assign absZero  = (pos[4:0] == 5'h0);
    // The mover answers never in the request cycle, as a real one.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ackCnt    <= 0;
            offsetAck <= 1'b0;
        end else begin
            ackCnt    <= offsetReq ? int'(ackDelay) + 1 :
                         (ackCnt > 0 ? ackCnt - 1 : 0);
            offsetAck <= (ackCnt == 1);
        end
    end
endmodule : hsq_axis_model
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the homing sequencer.
module tb;
    import hsq_pkg::*;
    localparam int PPR = 10000;
    logic ref_clk = 1'b0, rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, offsetPulses, rd;
    logic pready, pslverr, se, moveEnable, moveReverse, offsetReq;
    logic servoEnable = 1'b0, homeStartInput = 1'b0;
    logic forceFwd = 1'b0, forceRev = 1'b0, fwdM, revM, orgM, zM, absM;
    logic offsetAck, homeBusy, homeDone, fwdWarn, revWarn;
    logic [2:0] stepDiv = 3'h0;
    logic [3:0] ackDelay = 4'h0;
    logic [10:0] speedCmd;
    logic [15:0] offsetTurns;
    wire logic fwdIn = fwdM | forceFwd;
    wire logic revIn = revM | forceRev;
    int err_count = 0, samples_checked = 0, cycles = 0, fastE, slowE;
    hsq_homing #(.PULSES_PER_REV(PPR)) uut (.ref_clk(ref_clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .servoEnable(servoEnable),
        .homeStartInput(homeStartInput), .forwardLimitInput(fwdIn),
        .reverseLimitInput(revIn), .originSensorInput(orgM),
        .indexPulse(zM), .singleTurnZero(absM), .offsetAck(offsetAck),
        .moveEnable(moveEnable), .moveReverse(moveReverse),
        .speedCmd(speedCmd), .offsetReq(offsetReq),
        .offsetTurns(offsetTurns), .offsetPulses(offsetPulses),
        .homeBusy(homeBusy), .homeDone(homeDone),
        .forwardLimitWarn(fwdWarn), .reverseLimitWarn(revWarn));
    hsq_axis_model axis (.ref_clk(ref_clk), .rst_n(rst_n),
        .stepDiv(stepDiv), .ackDelay(ackDelay), .moveEnable(moveEnable),
        .moveReverse(moveReverse), .offsetReq(offsetReq),
        .fwdLimit(fwdM), .revLimit(revM), .origin(orgM), .zMark(zM),
        .absZero(absM), .offsetAck(offsetAck));
    // Free-running 200 MHz clock.
    always #2.5 ref_clk = ~ref_clk;
    // A hang ends the run as a failure.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            report_and_stop();
        end
    end
    function automatic int clamp(input int v, input int lo, input int hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp
    function automatic logic pick(input int s);
        case (s)
            0: return homeBusy;
            1: return offsetReq;
            2: return homeDone;
            3: return (speedCmd !== fastE[10:0]) || offsetReq;
            4: return fwdWarn;
            default: return revWarn;
        endcase
    endfunction : pick
    task automatic check(input string nm, input logic [31:0] exp,
                         input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    // Master holds the request until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        check("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_hi(input int s, input string nm, input int lim);
        int n = 0;
        while (pick(s) !== 1'b1 && n < lim) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check(nm, 32'h1, {31'h0, pick(s)});
    endtask : wait_hi
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            check("busy", 32'h0, {31'h0, homeBusy});
        end
    endtask : quiet
    task automatic do_reset();
        @(posedge ref_clk);
        rst_n          <= 1'b0;
        servoEnable    <= 1'b0;
        homeStartInput <= 1'b0;
        forceFwd       <= 1'b0;
        forceRev       <= 1'b0;
        stepDiv        <= 3'($urandom);
        ackDelay       <= 4'($urandom);
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask : do_reset
    // One homing run, its expectations worked out from the settings.
    task automatic run(input int rs, input int fn, input int md,
                       input int fs, input int sl, input int tu, input int pu);
        logic cDir, fDir;
        int tE, pE;
        do_reset();
        fastE = clamp(fs, 1, 2000);
        slowE = clamp(sl, 1, 500);
        tE    = clamp(tu, -30000, 30000);
        pE    = clamp(pu, -PPR, PPR);
        cDir  = rs[0];
        fDir  = (rs < 4 && fn == 0) ? !cDir : cDir;
        apb(1'b1, HSQ_CTRL_OFS, 32'(rs) | (32'(fn) << HSQ_FINE_LSB) |
            (32'(md) << HSQ_MODE_LSB));
        apb(1'b1, HSQ_FAST_OFS, 32'(fs));
        apb(1'b1, HSQ_SLOW_OFS, 32'(sl));
        apb(1'b1, HSQ_TURNS_OFS, 32'(tu));
        apb(1'b1, HSQ_PULSES_OFS, 32'(pu));
        apb(1'b0, HSQ_FAST_OFS, 32'h0);
        check("fast", 32'(fastE), rd);
        apb(1'b0, HSQ_SLOW_OFS, 32'h0);
        check("slow", 32'(slowE), rd);
        @(posedge ref_clk);
        servoEnable <= 1'b1;
        @(posedge ref_clk);
        homeStartInput <= (md != 1);
        if (md == 0) begin
            quiet(40);
            return;
        end
        wait_hi(0, "busy", 40);
        check("dir", {31'h0, cDir}, {31'h0, moveReverse});
        check("speed", 32'((rs >= 4) ? slowE : fastE), 32'(speedCmd));
        check("move", 32'h1, {31'h0, moveEnable});
        @(posedge ref_clk);
        homeStartInput <= 1'b0;
        @(posedge ref_clk);
        homeStartInput <= (md == 2);
        #1;
        if (rs < 4 && fn != 2) begin
            wait_hi(3, "stage", 600);
            check("fineDir", {31'h0, fDir}, {31'h0, moveReverse});
            check("fineSpd", 32'(slowE), 32'(speedCmd));
        end
        wait_hi(1, "offsetReq", 600);
        check("turns", {16'h0, 16'(tE)}, {16'h0, offsetTurns});
        check("pulses", 32'(pE), offsetPulses);
        check("stop", 32'h0, {31'h0, moveEnable});
        wait_hi(2, "done", 60);
        check("busyEnd", 32'h0, {31'h0, homeBusy});
        apb(1'b0, HSQ_STATUS_OFS, 32'h0);
        check("status", 32'h82, rd & 32'h9f);
        @(posedge ref_clk);
        forceFwd       <= (rs == 0);
        forceRev       <= (rs == 1);
        homeStartInput <= 1'b0;
        servoEnable    <= (md == 2);
        #1;
        if (rs < 2) wait_hi(4 + rs, "limitWarn", 8);
        @(posedge ref_clk);
        servoEnable <= 1'b1;
        quiet(30);
    endtask : run
    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", samples_checked,
                 err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // Reset values, bus refusals, then every start mode and reference.
    initial begin
        logic [7:0] ofs [6] = '{HSQ_CTRL_OFS, HSQ_FAST_OFS, HSQ_SLOW_OFS,
                                HSQ_TURNS_OFS, HSQ_PULSES_OFS, HSQ_STATUS_OFS};
        int rv [6] = '{0, 1000, 50, 0, 0, 0};
        void'($urandom(30052));
        do_reset();
        foreach (ofs[i]) begin
            apb(1'b0, ofs[i], 32'h0);
            check("resetVal", 32'(rv[i]), rd);
        end
        apb(1'b1, HSQ_STATUS_OFS, 32'hffffffff);
        apb(1'b0, HSQ_STATUS_OFS, 32'h0);
        check("statusRO", 32'h0, rd);
        apb(1'b1, 8'h18, 32'h5);
        check("slverr", 32'h1, {31'h0, se});
        apb(1'b1, HSQ_CTRL_OFS, 32'h1 << HSQ_STOP_BIT);
        apb(1'b0, HSQ_CTRL_OFS, 32'h0);
        check("stopSel", 32'h1 << HSQ_STOP_BIT, rd);
        run(2, 0, 0, 1000, 50, 0, 0);
        run(4, 0, 1, 0, 600, -40000, 20000);
        // Limit references also try fine 0, the recommended choice.
        for (int r = 0; r < 6; r++) begin
            for (int f = 0; f < 3; f++) begin
                run(r, f, 2, 501 + int'($urandom % 1500),
                    1 + int'($urandom % 500), int'($urandom % 60001) - 30000,
                    int'($urandom % 20001) - PPR);
            end
        end
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
